// *** hdl/mcr_cache_read.sv ***
/*
 Device-side serial front end for multi-line cache reads (x4, dual IO,
 quad IO), with the dual-clock FIFO that feeds it cache bytes.
 Assumes an external cache with a request/valid read port on mclk_i,
 a host that drives the serial clock only while chip select is low,
 and a quad permit level from the feature register on mclk_i.
*/
// Functional notes
// - x4 cache read accepted only with quad permit set.
// - Dual IO: four dummy bits then 12-bit column, on two lines.
// - Dual IO: four dummy clocks after column; inputs sampled on rising edge.
// - Dual IO data: two bits per clock on lines zero and one.
// - Output starts at exactly the given column.
// - Dual IO: column advances by one per byte up to wrap point.
// - Quad IO: dummy bits, 12-bit column, dummy phase on four lines.
// - Quad IO data: four bits per clock on all four lines.
// - Quad IO: column increments per byte up to wrap point.
// - Quad IO executes only with quad permit set.
// - At page end column wraps to zero; streaming until chip select high.
// - Dummy phase is four clocks for dual IO and quad IO.
`timescale 1ns/100ps

module mcr_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   // Write side
   input wire logic wclk_i,
   input wire logic wrst_i,
   input wire logic w_valid_i,
   output logic w_ready_o,
   input wire logic [WIDTH-1:0] w_data_i,
   // Read side
   input wire logic rclk_i,
   input wire logic rrst_i,
   output logic r_valid_o,
   input wire logic r_ready_i,
   output logic [WIDTH-1:0] r_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW:0] wbin_r, wgray_r, rbin_r, rgray_r;
   logic [AW:0] rg_s1_r, rg_s2_r, wg_s1_r, wg_s2_r;
   logic [AW:0] wbin_nxt, rbin_nxt;
   wire w_fire;
   wire r_fire;

   function automatic logic [AW:0] to_gray(input logic [AW:0] b);
      to_gray = b ^ (b >> 1);
   endfunction

   // Full and empty from synchronised gray pointers
   assign w_ready_o = (wgray_r != {~rg_s2_r[AW:AW-1], rg_s2_r[AW-2:0]});
   assign r_valid_o = (rgray_r != wg_s2_r);
   assign r_data_o = mem_r[rbin_r[AW-1:0]];
   assign w_fire = w_valid_i & w_ready_o;
   assign r_fire = r_valid_o & r_ready_i;
   assign wbin_nxt = wbin_r + (AW+1)'(w_fire);
   assign rbin_nxt = rbin_r + (AW+1)'(r_fire);

   // Write pointer and read pointer sync
   always_ff @(posedge wclk_i) begin
      if (wrst_i) begin
         wbin_r <= '0;
         wgray_r <= '0;
         rg_s1_r <= '0;
         rg_s2_r <= '0;
      end else begin
         wbin_r <= wbin_nxt;
         wgray_r <= to_gray(wbin_nxt);
         rg_s1_r <= rgray_r;
         rg_s2_r <= rg_s1_r;
      end
   end

   // Storage write
   always_ff @(posedge wclk_i) begin
      if (w_fire) begin
         mem_r[wbin_r[AW-1:0]] <= w_data_i;
      end
   end

   // Read pointer and write pointer sync; link clock may stop
   always_ff @(posedge rclk_i or posedge rrst_i) begin
      if (rrst_i) begin
         rbin_r <= '0;
         rgray_r <= '0;
         wg_s1_r <= '0;
         wg_s2_r <= '0;
      end else begin
         rbin_r <= rbin_nxt;
         rgray_r <= to_gray(rbin_nxt);
         wg_s1_r <= wgray_r;
         wg_s2_r <= wg_s1_r;
      end
   end
endmodule // mcr_fifo

module mcr_cache_read #(
   parameter logic [11:0] COL_LAST = mcr_pkg::COL_LAST_DEF
) (
   // System clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // Serial link
   input wire logic sclk_i,
   input wire logic cs_n_i,
   input wire logic [3:0] bidir_line_i,
   output logic [3:0] bidir_line_o,
   output logic [3:0] bidir_line_oe_o,
   // Feature bit
   input wire logic quad_io_permit_i,
   // Cache read port
   output logic cache_rd_req_o,
   output logic [11:0] cache_rd_addr_o,
   input wire logic cache_rd_valid_i,
   input wire logic [7:0] cache_rd_data_i
);

   // ---------------- link domain ----------------
   mcr_pkg::mcr_lstate_t st_r;
   mcr_pkg::mcr_prof_t prof_r;
   mcr_pkg::mcr_word_t head;
   logic [4:0] cnt_r;
   logic [6:0] opc_sh_r;
   logic [15:0] addr_sh_r;
   logic [7:0] byte_sh_r;
   logic [3:0] dout_r, oe_r;
   logic perm_s1_r, perm_s2_r;
   logic req_tgl_r;
   logic [11:0] col_hold_r;
   logic r_valid;

   function automatic logic [15:0] shift_in(input logic [15:0] sh, input logic [3:0] din, input logic [2:0] w);
      case (w)
         mcr_pkg::W4: shift_in = {sh[11:0], din};
         mcr_pkg::W2: shift_in = {sh[13:0], din[1:0]};
         default: shift_in = {sh[14:0], din[0]};
      endcase
   endfunction

   function automatic logic [3:0] top_bits(input logic [7:0] b, input logic [2:0] w);
      case (w)
         mcr_pkg::W4: top_bits = b[7:4];
         mcr_pkg::W2: top_bits = {2'h0, b[7:6]};
         default: top_bits = {3'h0, b[7]};
      endcase
   endfunction

   wire [7:0] opc_full = {opc_sh_r, bidir_line_i[0]};
   wire [15:0] addr_full = shift_in(addr_sh_r, bidir_line_i, prof_r.addr_w);
   wire opc_done = (st_r == mcr_pkg::ST_OPC) && (cnt_r == mcr_pkg::OPC_LAST);
   wire addr_done = (st_r == mcr_pkg::ST_ADDR) && (cnt_r == prof_r.addr_last);
   wire dummy_done = (st_r == mcr_pkg::ST_DUMMY) && (cnt_r == prof_r.dummy_last);
   wire slice_done = (st_r == mcr_pkg::ST_DATA) && (cnt_r == prof_r.slice_last);
   wire load_now = dummy_done | slice_done;
   wire in_read = (st_r == mcr_pkg::ST_DUMMY) || (st_r == mcr_pkg::ST_DATA);
   wire head_fresh = r_valid && in_read && (head.epoch == req_tgl_r);
   wire head_stale = r_valid && !(in_read && (head.epoch == req_tgl_r));
   wire r_ready = head_stale | (load_now & head_fresh);
   wire [7:0] next_byte = head_fresh ? head.data : mcr_pkg::UNDERRUN_BYTE;
   wire [7:0] shifted_byte = byte_sh_r << prof_r.data_w;
   wire is_x4 = (opc_full == mcr_pkg::OPC_READ_X4);
   wire is_dual = (opc_full == mcr_pkg::OPC_READ_DUAL_IO);
   wire is_quad = (opc_full == mcr_pkg::OPC_READ_QUAD_IO);
   wire opc_ok = is_dual | ((is_x4 | is_quad) & perm_s2_r);
   mcr_pkg::mcr_prof_t prof_sel;
   assign prof_sel = is_x4 ? mcr_pkg::PROF_X4 : (is_quad ? mcr_pkg::PROF_QUAD : mcr_pkg::PROF_DUAL);

   // Quad permit crosses into the link clock
   always_ff @(posedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         perm_s1_r <= 1'b0;
         perm_s2_r <= 1'b0;
      end else begin
         perm_s1_r <= quad_io_permit_i;
         perm_s2_r <= perm_s1_r;
      end
   end

   // Start request toggle and held column, kept across frames
   always_ff @(posedge sclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         req_tgl_r <= 1'b0;
         col_hold_r <= '0;
      end else if (addr_done) begin
         req_tgl_r <= ~req_tgl_r;
         col_hold_r <= addr_full[mcr_pkg::COL_W-1:0];
      end
   end

   // Frame sequencer; chip select high ends the frame at once
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         st_r <= mcr_pkg::ST_OPC;
         prof_r <= mcr_pkg::PROF_DUAL;
         cnt_r <= '0;
         opc_sh_r <= '0;
         addr_sh_r <= '0;
      end else begin
         cnt_r <= cnt_r + 5'h01;
         case (st_r)
            mcr_pkg::ST_OPC: begin
               opc_sh_r <= opc_full[6:0];
               if (opc_done) begin
                  cnt_r <= '0;
                  prof_r <= prof_sel;
                  st_r <= opc_ok ? mcr_pkg::ST_ADDR : mcr_pkg::ST_IGNORE;
               end
            end
            mcr_pkg::ST_ADDR: begin
               addr_sh_r <= addr_full;
               if (addr_done) begin
                  cnt_r <= '0;
                  st_r <= mcr_pkg::ST_DUMMY;
               end
            end
            mcr_pkg::ST_DUMMY: begin
               if (dummy_done) begin
                  cnt_r <= '0;
                  st_r <= mcr_pkg::ST_DATA;
               end
            end
            mcr_pkg::ST_DATA: begin
               if (slice_done) begin
                  cnt_r <= '0;
               end
            end
            mcr_pkg::ST_IGNORE: begin
               cnt_r <= cnt_r;
            end
            default: begin
               st_r <= mcr_pkg::ST_IGNORE;
            end
         endcase
      end
   end

   // Data shifter and line drivers
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         byte_sh_r <= '0;
         dout_r <= '0;
         oe_r <= mcr_pkg::OE_NONE;
      end else if (load_now) begin
         byte_sh_r <= next_byte << prof_r.data_w;
         dout_r <= top_bits(next_byte, prof_r.data_w);
         oe_r <= prof_r.data_oe;
      end else if (st_r == mcr_pkg::ST_DATA) begin
         byte_sh_r <= shifted_byte;
         dout_r <= top_bits(byte_sh_r, prof_r.data_w);
      end
   end

   assign bidir_line_o = dout_r;
   assign bidir_line_oe_o = oe_r;

   // ---------------- system domain ----------------
   mcr_pkg::mcr_fstate_t fst_r;
   mcr_pkg::mcr_word_t push_word;
   logic cs_s1_r, cs_s2_r;
   logic tg_s1_r, tg_s2_r, tg_s3_r;
   logic epoch_r, issue_epoch_r;
   logic [11:0] col_r, rd_addr_r;
   logic rd_req_r;
   logic w_ready;
   wire new_cmd = tg_s2_r ^ tg_s3_r;
   wire push = cache_rd_valid_i && (fst_r == mcr_pkg::F_WAIT);
   // Next column, wrapping at the page end
   function automatic logic [11:0] col_step(input logic [11:0] c);
      col_step = (c == COL_LAST) ? 12'h000 : c + 12'h001;
   endfunction

   wire [11:0] col_inc = col_step(col_r);
   assign push_word = '{issue_epoch_r, cache_rd_data_i};

   // Chip select and start toggle synchronisers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         cs_s1_r <= 1'b1;
         cs_s2_r <= 1'b1;
         tg_s1_r <= 1'b0;
         tg_s2_r <= 1'b0;
         tg_s3_r <= 1'b0;
      end else begin
         cs_s1_r <= cs_n_i;
         cs_s2_r <= cs_s1_r;
         tg_s1_r <= req_tgl_r;
         tg_s2_r <= tg_s1_r;
         tg_s3_r <= tg_s2_r;
      end
   end

   // Prefetch engine: reads cache bytes ahead into the FIFO
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         fst_r <= mcr_pkg::F_IDLE;
         epoch_r <= 1'b0;
         issue_epoch_r <= 1'b0;
         col_r <= '0;
         rd_addr_r <= '0;
         rd_req_r <= 1'b0;
      end else begin
         rd_req_r <= 1'b0;
         if (new_cmd) begin
            col_r <= col_hold_r;
            epoch_r <= tg_s2_r;
         end
         case (fst_r)
            mcr_pkg::F_IDLE: begin
               // First fetch goes out at once so the byte beats the dummy phase
               if (new_cmd && w_ready) begin
                  rd_req_r <= 1'b1;
                  rd_addr_r <= col_hold_r;
                  issue_epoch_r <= tg_s2_r;
                  col_r <= col_step(col_hold_r);
                  fst_r <= mcr_pkg::F_WAIT;
               end else if (new_cmd) begin
                  fst_r <= mcr_pkg::F_RUN;
               end
            end
            mcr_pkg::F_RUN: begin
               if (cs_s2_r) begin
                  fst_r <= mcr_pkg::F_IDLE;
               end else if (w_ready && !new_cmd) begin
                  rd_req_r <= 1'b1;
                  rd_addr_r <= col_r;
                  issue_epoch_r <= epoch_r;
                  col_r <= col_inc;
                  fst_r <= mcr_pkg::F_WAIT;
               end
            end
            mcr_pkg::F_WAIT: begin
               if (cache_rd_valid_i) begin
                  fst_r <= (cs_s2_r && !new_cmd) ? mcr_pkg::F_IDLE : mcr_pkg::F_RUN;
               end
            end
            default: begin
               fst_r <= mcr_pkg::F_IDLE;
            end
         endcase
      end
   end

   assign cache_rd_req_o = rd_req_r;
   assign cache_rd_addr_o = rd_addr_r;

   // Byte FIFO crossing from system clock to link clock
   mcr_fifo #(
      .WIDTH(mcr_pkg::WORD_W),
      .DEPTH(mcr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .wclk_i(mclk_i),
      .wrst_i(sys_rst_i),
      .w_valid_i(push),
      .w_ready_o(w_ready),
      .w_data_i(push_word),
      .rclk_i(sclk_i),
      .rrst_i(sys_rst_i),
      .r_valid_o(r_valid),
      .r_ready_i(r_ready),
      .r_data_o(head)
   );
endmodule // mcr_cache_read

// *** inc/mcr_pkg.sv ***
/*
 Shared constants and types of the multi-line cache read front end:
 opcodes, phase profiles per command, FIFO word layout, state codes.
 Assumes a host that frames every command with chip select low.
*/
package mcr_pkg;

   // Opcodes served by this block
   localparam logic [7:0] OPC_READ_X4 = 8'h6B;
   localparam logic [7:0] OPC_READ_DUAL_IO = 8'hBB;
   localparam logic [7:0] OPC_READ_QUAD_IO = 8'hEB;

   // Frame geometry
   localparam int COL_W = 12;
   localparam int ADDR_SH_W = 16;
   localparam logic [4:0] OPC_LAST = 5'h07;
   localparam logic [11:0] COL_LAST_DEF = 12'hFFF;
   localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;

   // Line widths and enables
   localparam logic [2:0] W1 = 3'h1;
   localparam logic [2:0] W2 = 3'h2;
   localparam logic [2:0] W4 = 3'h4;
   localparam logic [3:0] OE_NONE = 4'h0;
   localparam logic [3:0] OE_DUAL = 4'h3;
   localparam logic [3:0] OE_QUAD = 4'hF;

   // Phase profile of one command; counts are last index (clocks - 1)
   typedef struct packed {
      logic [4:0] addr_last;
      logic [4:0] dummy_last;
      logic [2:0] addr_w;
      logic [2:0] data_w;
      logic [4:0] slice_last;
      logic [3:0] data_oe;
   } mcr_prof_t;

   // x4: 16 address clocks on one line, 8 dummy clocks, data on four lines
   localparam mcr_prof_t PROF_X4 = '{5'h0F, 5'h07, W1, W4, 5'h01, OE_QUAD};
   // Dual IO: 8 address clocks on two lines, 4 dummy clocks, data on two lines
   localparam mcr_prof_t PROF_DUAL = '{5'h07, 5'h03, W2, W2, 5'h03, OE_DUAL};
   // Quad IO: 4 address clocks on four lines, 4 dummy clocks, data on four lines
   localparam mcr_prof_t PROF_QUAD = '{5'h03, 5'h03, W4, W4, 5'h01, OE_QUAD};

   // FIFO word: command epoch tag and one cache byte
   typedef struct packed {
      logic epoch;
      logic [7:0] data;
   } mcr_word_t;
   localparam int WORD_W = 9;
   localparam int FIFO_DEPTH = 4;

   // Link-side frame states
   typedef enum logic [4:0] {
      ST_OPC = 5'h01,
      ST_ADDR = 5'h02,
      ST_DUMMY = 5'h04,
      ST_DATA = 5'h08,
      ST_IGNORE = 5'h10
   } mcr_lstate_t;

   // System-side fetch states
   typedef enum logic [2:0] {
      F_IDLE = 3'h1,
      F_RUN = 3'h2,
      F_WAIT = 3'h4
   } mcr_fstate_t;

endpackage

// *** testbench/mcr_cache_read_assertions.sv ***
/* Checker for the cache read front end.
   Assumes it is bound to mcr_cache_read and sees only its ports. */
`timescale 1ns/100ps
module mcr_cache_read_chk #(
   parameter logic [11:0] COL_LAST = 12'hFFF
) (
   // Clocks and resets
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   input wire logic sclk_i,
   input wire logic cs_n_i,
   // Link and permit
   input wire logic [3:0] bidir_line_i,
   input wire logic [3:0] bidir_line_oe_o,
   input wire logic quad_io_permit_i,
   // Cache port
   input wire logic cache_rd_req_o,
   input wire logic [11:0] cache_rd_addr_o
);
   logic [5:0] edge_cnt;
   logic [7:0] opc_r;
   logic [11:0] last_col_r;
   logic in_frame_r;
   logic opc_ok;
   assign opc_ok = opc_r inside {8'h6B, 8'hBB, 8'hEB};
   // Edge count and opcode of the open frame
   always_ff @(posedge sclk_i or posedge cs_n_i) begin
      if (cs_n_i) begin
         edge_cnt <= 6'h00;
         opc_r <= 8'h00;
      end else begin
         if (edge_cnt != 6'h3F) edge_cnt <= edge_cnt + 6'h01;
         if (edge_cnt < 6'h08) opc_r <= {opc_r[6:0], bidir_line_i[0]};
      end
   end
   // Last fetched column within a frame
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || cs_n_i) in_frame_r <= 1'b0;
      else if (cache_rd_req_o) in_frame_r <= 1'b1;
      if (cache_rd_req_o) last_col_r <= cache_rd_addr_o;
   end
   a_req_pulse: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      cache_rd_req_o |=> !cache_rd_req_o) else $error("request longer than one cycle");
   a_addr_hold: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      !cache_rd_req_o |-> $stable(cache_rd_addr_o)) else $error("column moved without request");
   a_col_step: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
      in_frame_r && cache_rd_req_o && !cs_n_i |->
      cache_rd_addr_o == ((last_col_r == COL_LAST) ? 12'h000 : last_col_r + 12'h001))
      else $error("column step wrong");
   a_quiet_head: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      edge_cnt <= 6'h0F |-> bidir_line_oe_o == 4'h0) else $error("early drive");
   a_dual_dummy: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      opc_r == 8'hBB && edge_cnt <= 6'h13 |-> bidir_line_oe_o == 4'h0) else $error("dual dummy short");
   a_dual_start: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      opc_r == 8'hBB && edge_cnt == 6'h14 |-> bidir_line_oe_o == 4'h3) else $error("dual data lines");
   a_quad_start: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      opc_r == 8'hEB && quad_io_permit_i && edge_cnt == 6'h10 |-> bidir_line_oe_o == 4'hF)
      else $error("quad data lines");
   a_x4_start: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      opc_r == 8'h6B && quad_io_permit_i && edge_cnt == 6'h20 |-> bidir_line_oe_o == 4'hF)
      else $error("x4 data lines");
   a_permit_gate: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      (opc_r == 8'h6B || opc_r == 8'hEB) && !quad_io_permit_i |-> bidir_line_oe_o == 4'h0)
      else $error("drive without permit");
   a_bad_opc: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      edge_cnt >= 6'h08 && !opc_ok |-> bidir_line_oe_o == 4'h0) else $error("unknown opcode served");
   a_oe_hold: assert property (@(posedge sclk_i) disable iff (cs_n_i)
      edge_cnt != 6'h00 && |$past(bidir_line_oe_o) |-> bidir_line_oe_o == $past(bidir_line_oe_o))
      else $error("drive dropped in frame");
   c_quad: cover property (@(posedge sclk_i) opc_r == 8'hEB && bidir_line_oe_o == 4'hF);
   c_dual: cover property (@(posedge sclk_i) opc_r == 8'hBB && bidir_line_oe_o == 4'h3);
   c_wrap: cover property (@(posedge mclk_i) in_frame_r && cache_rd_req_o && cache_rd_addr_o == 12'h000);
endmodule // mcr_cache_read_chk
bind mcr_cache_read mcr_cache_read_chk #(.COL_LAST(COL_LAST)) u_chk (
   .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i),
   .bidir_line_i(bidir_line_i), .bidir_line_oe_o(bidir_line_oe_o),
   .quad_io_permit_i(quad_io_permit_i), .cache_rd_req_o(cache_rd_req_o),
   .cache_rd_addr_o(cache_rd_addr_o));

// *** testbench/mcr_host_model.sv ***
/* Host serial controller model: frames, clocks and reads back bytes.
   Assumes resolved line levels come back on line_i. */
`timescale 1ns/100ps
module mcr_host_model (
   // Link outputs
   output logic sclk_o,
   output logic cs_n_o,
   output logic [3:0] line_o,
   // Resolved lines
   input wire logic [3:0] line_i
);
   logic [7:0] rx [0:15];
   logic [3:0] smp;
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      line_o = 4'h0;
   end
   task automatic clk1(input logic [3:0] v, input logic drv);
      sclk_o = 1'b0;
      line_o = drv ? v : ~line_o;
      #24;
      smp = line_i;
      sclk_o = 1'b1;
      #24;
   endtask
   task automatic frame(input logic [7:0] opc, input logic [11:0] col, input int nby);
      int aw;
      int dw;
      int dm;
      logic [15:0] a;
      logic [7:0] b;
      aw = (opc == 8'hBB) ? 2 : (opc == 8'hEB) ? 4 : 1;
      dw = (opc == 8'hBB) ? 2 : 4;
      dm = (opc == 8'h6B) ? 8 : 4;
      a = {4'hA, col};
      cs_n_o = 1'b0;
      #24;
      for (int i = 7; i >= 0; i--) clk1({3'h0, opc[i]}, 1'b1);
      for (int k = 0; k < 16 / aw; k++) clk1(4'(a >> (16 - aw * (k + 1))) & 4'((1 << aw) - 1), 1'b1);
      for (int k = 0; k < dm; k++) clk1(4'h0, 1'b0);
      for (int n = 0; n < nby; n++) begin
         b = 8'h00;
         for (int k = 0; k < 8 / dw; k++) begin
            clk1(4'h0, 1'b0);
            b = 8'(b << dw) | 8'(smp & 4'((1 << dw) - 1));
         end
         rx[n] = b;
      end
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      #200;
   endtask
endmodule // mcr_host_model

// *** testbench/multi_io_cache_read_bench.sv ***
/* Bench for mcr_cache_read with host and cache models.
   Assumes the checker is bound to the design. */
`timescale 1ns/100ps
module multi_io_cache_read_bench;
   localparam logic [11:0] COLL = 12'h00F;
   logic mclk_i;
   logic sys_rst_i;
   logic quad_io_permit_i;
   logic cache_rd_valid_i;
   logic [7:0] cache_rd_data_i;
   logic cache_rd_req_o;
   logic [11:0] cache_rd_addr_o;
   logic sclk;
   logic cs_n;
   logic [3:0] host_line;
   logic [3:0] line_i;
   logic [3:0] line_o;
   logic [3:0] line_oe;
   logic oe_seen;
   logic [3:0] oe_last;
   int mismatches;
   int checks;
   mcr_cache_read #(.COL_LAST(COLL)) dut (
      .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n),
      .bidir_line_i(line_i), .bidir_line_o(line_o), .bidir_line_oe_o(line_oe),
      .quad_io_permit_i(quad_io_permit_i), .cache_rd_req_o(cache_rd_req_o),
      .cache_rd_addr_o(cache_rd_addr_o), .cache_rd_valid_i(cache_rd_valid_i),
      .cache_rd_data_i(cache_rd_data_i));
   mcr_host_model hst (.sclk_o(sclk), .cs_n_o(cs_n), .line_o(host_line), .line_i(line_i));
   // Line level from both drivers
   assign line_i = (line_oe & line_o) | (~line_oe & host_line);
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end
   function automatic logic [7:0] cdat(input logic [11:0] c);
      return c[7:0] + 8'h11;
   endfunction
   // Cache answers one cycle after a request
   always @(negedge mclk_i) begin
      cache_rd_valid_i <= cache_rd_req_o;
      cache_rd_data_i <= cdat(cache_rd_addr_o);
   end
   // Link enables seen inside frames, read before the edge updates them
   always @(posedge sclk) begin
      if (!cs_n) begin
         oe_seen = oe_seen | (|line_oe);
         oe_last = line_oe;
      end
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic set_permit(input logic v);
      @(negedge mclk_i);
      quad_io_permit_i = v;
      repeat (5) @(negedge mclk_i);
   endtask
   // One frame, then lines and bytes judged
   task automatic run_read(input logic [7:0] opc, input logic [11:0] col, input int n, input logic [3:0] eoe);
      logic [11:0] c;
      c = col;
      oe_seen = 1'b0;
      oe_last = 4'h0;
      hst.frame(opc, col, n);
      chk4(oe_last, eoe);
      for (int i = 0; i < n; i++) begin
         if (eoe != 4'h0) chk8(hst.rx[i], cdat(c));
         c = (c == COLL) ? 12'h000 : c + 12'h001;
      end
   endtask
   task automatic t_quad_wrap;
      set_permit(1'b1);
      run_read(mcr_pkg::OPC_READ_QUAD_IO, 12'h00C, 8, mcr_pkg::OE_QUAD);
   endtask
   task automatic t_dual_wrap;
      set_permit(1'b0);
      run_read(mcr_pkg::OPC_READ_DUAL_IO, 12'h00E, 5, mcr_pkg::OE_DUAL);
   endtask
   task automatic t_x4;
      set_permit(1'b1);
      run_read(mcr_pkg::OPC_READ_X4, 12'h005, 3, mcr_pkg::OE_QUAD);
   endtask
   task automatic t_back;
      set_permit(1'b1);
      run_read(mcr_pkg::OPC_READ_QUAD_IO, COLL, 2, mcr_pkg::OE_QUAD);
      run_read(mcr_pkg::OPC_READ_DUAL_IO, 12'h000, 3, mcr_pkg::OE_DUAL);
   endtask
   task automatic t_refused;
      logic [7:0] ops [3];
      ops = '{8'hEB, 8'h6B, 8'h03};
      for (int i = 0; i < 3; i++) begin
         set_permit(i == 2);
         run_read(ops[i], 12'h003, 2, 4'h0);
         chk4({3'h0, oe_seen}, 4'h0);
      end
   endtask
   task automatic final_report;
      $display("mismatches=%0d checks=%0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      sys_rst_i = 1'b1;
      quad_io_permit_i = 1'b0;
      cache_rd_valid_i = 1'b0;
      cache_rd_data_i = 8'h00;
      mismatches = 0;
      checks = 0;
      oe_seen = 1'b0;
      oe_last = 4'h0;
      repeat (10) @(negedge mclk_i);
      sys_rst_i = 1'b0;
      t_quad_wrap();
      t_dual_wrap();
      t_x4();
      t_back();
      t_refused();
      final_report();
   end
   // Hang guard
   initial begin
      #1000000;
      mismatches++;
      final_report();
   end
endmodule // multi_io_cache_read_bench
